// ### inc/ttrc_regs.svh
// Register addresses, field positions and timing constants.
`ifndef TTRC_REGS_SVH
`define TTRC_REGS_SVH
`define TTRC_ADDR_W 11
`define TTRC_CFG2_ADDR 11'h002
`define TTRC_STRT_ADDR 11'h003
`define TTRC_ISR1_ADDR 11'h010
`define TTRC_ISR2_ADDR 11'h011
`define TTRC_TAG_ADDR 11'h012
`define TTRC_CFG2_RST 16'h0000
`define TTRC_RES_HI 9
`define TTRC_RES_LO 7
`define TTRC_SYNCCLR_BIT 6
`define TTRC_SYNC_DATA_TO_TAG_BIT 5
`define TTRC_COR_BIT 4
`define TTRC_LEVEL_BIT 3
`define TTRC_SRAC_BIT 2
`define TTRC_ENH_BIT 1
`define TTRC_BSEP_BIT 0
`define TTRC_DBUF_BIT 12
`define TTRC_INC_BIT 4
`define TTRC_TRST_BIT 3
`define TTRC_ICLR_BIT 2
`define TTRC_RES_SOFT 3'h6
`define TTRC_RES_EXT 3'h7
`define TTRC_RES_MAX_SHIFT 5
`define TTRC_CLK_MHZ 125
`define TTRC_CLK_NS 8
`define TTRC_TAG_BASE_US 2
`define TTRC_PULSE_NS 500
`define TTRC_PULSE_CYC ((`TTRC_PULSE_NS + `TTRC_CLK_NS - 1) / `TTRC_CLK_NS)
`endif

// ### inc/ttrc_pkg.sv
// Shared types of the time tag and terminal configuration block.
package ttrc_pkg;
  typedef logic [15:0] ttrc_word_t;
  typedef enum logic [1:0] {TTRC_BC, TTRC_RT, TTRC_MT} ttrc_mode_t;
endpackage : ttrc_pkg

// ### inc/ttrc_cfg_if.sv
// Configuration fields and host strobes passed to the submodules.
`timescale 1ns/1ns
interface ttrc_cfg_if;
  logic [2:0] tag_resolution_sel;
  logic sync_clears_tag;
  logic sync_data_to_tag;
  logic tag_increment_strobe;
  logic tag_reset_strobe;
  logic irq_clear_on_read;
  logic irq_level_mode;
  logic irq_status_clear;
  logic isr1_rd;
  logic isr2_rd;
  modport ctl (
    output tag_resolution_sel, sync_clears_tag, sync_data_to_tag,
    output tag_increment_strobe, tag_reset_strobe,
    output irq_clear_on_read, irq_level_mode, irq_status_clear,
    output isr1_rd, isr2_rd
  );
  modport tag (
    input tag_resolution_sel, sync_clears_tag, sync_data_to_tag,
    input tag_increment_strobe, tag_reset_strobe
  );
  modport irq (
    input irq_clear_on_read, irq_level_mode, irq_status_clear,
    input isr1_rd, isr2_rd
  );
endinterface : ttrc_cfg_if

// ### verilog/ttrc_time_tag.sv
// Time tag counter with prescaler, soft, external and sync sources.
`timescale 1ns/1ns
`include "ttrc_regs.svh"
module ttrc_time_tag #(
  parameter int TAG_BASE_CYC = `TTRC_TAG_BASE_US * `TTRC_CLK_MHZ,
  parameter int PW = 16
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  ttrc_cfg_if.tag cfg,
  input wire logic rt_mode_in,
  input wire logic tag_clk_in,
  input wire logic sync_nodata_in,
  input wire logic sync_data_in,
  input wire ttrc_pkg::ttrc_word_t sync_word_in,
  output ttrc_pkg::ttrc_word_t tag_out
);
  logic [PW-1:0] presc_r, presc_nxt;
  logic ext_prev_r;
  ttrc_pkg::ttrc_word_t tag_nxt;
  logic [31:0] period_c;
  logic internal, tick, ext_rise, clr_ev, load_ev, adv;

  always_comb
  begin
    // Coarser settings are the base period doubled per code step.
    period_c = 32'(TAG_BASE_CYC) <<
      (3'(`TTRC_RES_MAX_SHIFT) - cfg.tag_resolution_sel); // [R1]
    internal = cfg.tag_resolution_sel < `TTRC_RES_SOFT;
    // Greater-or-equal, so a shorter period picked in mid-count ends at
    // once instead of letting the prescaler run round its full range.
    tick = internal && (32'(presc_r) >= period_c - 32'd1);
    presc_nxt = (tick || !internal) ? '0 : presc_r + 1'b1; // [R17]
    ext_rise = tag_clk_in && !ext_prev_r;
    clr_ev = cfg.tag_reset_strobe ||
      (rt_mode_in && cfg.sync_clears_tag && sync_nodata_in); // [R4]
    load_ev = rt_mode_in && cfg.sync_data_to_tag && sync_data_in;
    unique case (cfg.tag_resolution_sel)
      `TTRC_RES_SOFT: adv = cfg.tag_increment_strobe; // [R2] [R16]
      `TTRC_RES_EXT: adv = ext_rise; // [R3]
      default: adv = tick; // [R17]
    endcase
    tag_nxt = tag_out;
    if (clr_ev)
      tag_nxt = '0;
    else if (load_ev)
      tag_nxt = sync_word_in; // [R5]
    else if (adv)
      tag_nxt = tag_out + 16'h0001;
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      presc_r <= '0;
      ext_prev_r <= 1'b0;
      tag_out <= '0;
    end
    else
    begin
      presc_r <= presc_nxt;
      ext_prev_r <= tag_clk_in;
      tag_out <= tag_nxt;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  property p_sync_clr;
    rt_mode_in && cfg.sync_clears_tag && sync_nodata_in |=> tag_out == '0;
  endproperty
  a_sync_clr: assert property (p_sync_clr) // [R4]
    else $error("sync without data did not clear the tag");
  property p_sync_load;
    rt_mode_in && cfg.sync_data_to_tag && sync_data_in && !clr_ev
      |=> tag_out == $past(sync_word_in);
  endproperty
  a_sync_load: assert property (p_sync_load) // [R5]
    else $error("sync data word not loaded into the tag");
  property p_soft_hold;
    cfg.tag_resolution_sel == `TTRC_RES_SOFT && !clr_ev && !load_ev
      |=> tag_out == $past(tag_out) + 16'($past(cfg.tag_increment_strobe));
  endproperty
  a_soft_hold: assert property (p_soft_hold) // [R2]
    else $error("soft mode tag moved without the strobe");
  property p_ext_adv;
    cfg.tag_resolution_sel == `TTRC_RES_EXT && !clr_ev && !load_ev
      |=> tag_out == $past(tag_out) + 16'($past(ext_rise));
  endproperty
  a_ext_adv: assert property (p_ext_adv) // [R3]
    else $error("external clock edge not counted");
  property p_int_adv;
    internal && !clr_ev && !load_ev |=> $changed(tag_out) == $past(tick);
  endproperty
  a_int_adv: assert property (p_int_adv) // [R17]
    else $error("internal tag advance not on the period tick");
  property p_period;
    internal |=> 32'(presc_r) < $past(period_c);
  endproperty
  a_period: assert property (p_period) // [R1]
    else $error("prescaler ran past the selected period");
  c_ext_adv: cover property (ext_rise && adv);
endmodule : ttrc_time_tag

// ### verilog/ttrc_irq.sv
// Interrupt status registers and active-low interrupt output shaping.
`timescale 1ns/1ns
`include "ttrc_regs.svh"
module ttrc_irq #(
  parameter int PULSE_CYC = `TTRC_PULSE_CYC
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  ttrc_cfg_if.irq cfg,
  input wire ttrc_pkg::ttrc_word_t ev1_in,
  input wire ttrc_pkg::ttrc_word_t ev2_in,
  output ttrc_pkg::ttrc_word_t isr1_out,
  output ttrc_pkg::ttrc_word_t isr2_out,
  output logic int_n_out
);
  ttrc_pkg::ttrc_word_t isr1_nxt, isr2_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic int_n_nxt, clr1, clr2, any_ev;

  always_comb
  begin
    // A read clears only when clear-on-read is set.
    clr1 = cfg.irq_status_clear ||
      (cfg.irq_clear_on_read && cfg.isr1_rd); // [R7] [R8]
    clr2 = cfg.irq_status_clear ||
      (cfg.irq_clear_on_read && cfg.isr2_rd); // [R7] [R8]
    // Events arriving with a clear still set their bits.
    isr1_nxt = (clr1 ? '0 : isr1_out) | ev1_in;
    isr2_nxt = (clr2 ? '0 : isr2_out) | ev2_in;
    any_ev = (|ev1_in) || (|ev2_in);
    if (any_ev)
      cnt_nxt = 8'(PULSE_CYC); // [R10]
    else if (cnt_r != '0)
      cnt_nxt = cnt_r - 8'h01;
    else
      cnt_nxt = '0;
    if (cfg.irq_level_mode)
      int_n_nxt = !((|isr1_nxt) || (|isr2_nxt)); // [R9]
    else
      int_n_nxt = cnt_nxt == '0; // [R10]
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      isr1_out <= '0;
      isr2_out <= '0;
      cnt_r <= '0;
      int_n_out <= 1'b1;
    end
    else
    begin
      isr1_out <= isr1_nxt;
      isr2_out <= isr2_nxt;
      cnt_r <= cnt_nxt;
      int_n_out <= int_n_nxt;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  property p_cor;
    cfg.irq_clear_on_read && cfg.isr1_rd && ev1_in == '0 |=> isr1_out == '0;
  endproperty
  a_cor: assert property (p_cor) // [R7]
    else $error("status 1 not cleared by its read");
  property p_keep;
    !cfg.irq_clear_on_read && !cfg.irq_status_clear
      |=> (isr1_out & $past(isr1_out)) == $past(isr1_out) &&
          (isr2_out & $past(isr2_out)) == $past(isr2_out);
  endproperty
  a_keep: assert property (p_keep) // [R8]
    else $error("status cleared without a clear strobe");
  property p_level;
    $past(cfg.irq_level_mode)
      |-> int_n_out == !((|isr1_out) || (|isr2_out));
  endproperty
  a_level: assert property (p_level) // [R9]
    else $error("level interrupt does not follow status");
  property p_pulse_len;
    !cfg.irq_level_mode && any_ev ##1 !cfg.irq_level_mode && !any_ev
      |-> !int_n_out ##(PULSE_CYC) int_n_out;
  endproperty
  a_pulse_len: assert property (p_pulse_len) // [R10]
    else $error("interrupt pulse width wrong");
  c_pulse: cover property (!cfg.irq_level_mode && $rose(int_n_out));
  c_cor: cover property (cfg.irq_clear_on_read && cfg.isr2_rd);
endmodule : ttrc_irq

// ### verilog/ttrc_top.sv
// Configuration register 2 low fields with time tag and interrupt control.
// What this block does
// R1: Resolution codes 000 to 101 pick 64, 32, 16, 8, 4, 2 us per count.
// R2: Code 110 advances the tag only on a software increment write.
// R3: Code 111 advances the tag on external tag clock rising edges.
// R4: RT mode with sync-clear set zeroes the tag on sync without data.
// R5: RT mode with sync-data set loads the sync data word into the tag.
// R6: BC mode with sync-data set sends the tag as sync data word.
// R7: Clear-on-read set clears each status register when the host reads it.
// R8: Clear-on-read off: reads keep status; start/reset bit 2 clears both.
// R9: Level mode holds the low interrupt until both status registers clear.
// R10: Pulse mode gives a 504 ns (63 cycle) low pulse, restarted by each cycle with an event.
// R11: Service request changes by host only, or also clears on vector answer.
// R12: Enhanced buffering off: global double or single receive buffering.
// R13: Enhanced buffering on: each subaddress control word picks its mode.
// R14: Broadcast separation on: broadcast data goes to separate buffers.
// R15: Broadcast separation off: broadcast data shares the normal buffer.
// R16: Increment write adds one count only in software increment mode.
// R17: Internal settings count every selected period and wrap at maximum.
`timescale 1ns/1ns
`include "ttrc_regs.svh"
module ttrc_top #(
  parameter int TAG_BASE_CYC = `TTRC_TAG_BASE_US * `TTRC_CLK_MHZ,
  parameter int PULSE_CYC = `TTRC_PULSE_CYC
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [`TTRC_ADDR_W-1:0] host_addr_in,
  input wire logic host_wr_in,
  input wire logic host_rd_in,
  input wire logic [15:0] host_wdata_in,
  output logic [15:0] host_rdata_out,
  input wire logic [1:0] mode_in,
  input wire logic tag_clk_in,
  input wire logic sync_nodata_rx_in,
  input wire logic sync_data_rx_in,
  input wire logic [15:0] sync_word_in,
  input wire logic [15:0] bc_msg_word_in,
  output logic [15:0] bc_sync_word_out,
  output logic [15:0] tag_value_out,
  input wire logic [15:0] irq_events1_in,
  input wire logic [15:0] irq_events2_in,
  output logic int_n_out,
  input wire logic svc_req_wr_in,
  input wire logic svc_req_val_in,
  input wire logic vector_answered_in,
  output logic svc_req_out,
  input wire logic rx_sa_ctrl_double_in,
  output logic rx_double_buf_out,
  input wire logic rx_bcst_cmd_in,
  output logic rx_bcst_buf_out
);
  ttrc_cfg_if cfg ();

  logic [15:0] cfg2_r, cfg2_nxt;
  logic [15:0] rdata_nxt;
  logic inc_r, inc_nxt;
  logic trst_r, trst_nxt;
  logic iclr_r, iclr_nxt;
  logic svc_nxt;
  logic dbl_nxt;
  logic bcst_nxt;
  logic [15:0] bc_word_nxt;
  logic wr_cfg2, wr_strt;
  logic bc_mode, rt_mode;
  ttrc_pkg::ttrc_mode_t mode;
  ttrc_pkg::ttrc_word_t isr1, isr2;

  assign mode = ttrc_pkg::ttrc_mode_t'(mode_in);
  assign bc_mode = mode == ttrc_pkg::TTRC_BC;
  assign rt_mode = mode == ttrc_pkg::TTRC_RT;

  // Field view of the register towards the submodules.
  always_comb
  begin
    cfg.tag_resolution_sel = cfg2_r[`TTRC_RES_HI:`TTRC_RES_LO];
    cfg.sync_clears_tag = cfg2_r[`TTRC_SYNCCLR_BIT];
    cfg.sync_data_to_tag = cfg2_r[`TTRC_SYNC_DATA_TO_TAG_BIT];
    cfg.irq_clear_on_read = cfg2_r[`TTRC_COR_BIT];
    cfg.irq_level_mode = cfg2_r[`TTRC_LEVEL_BIT];
    cfg.tag_increment_strobe = inc_r;
    cfg.tag_reset_strobe = trst_r;
    cfg.irq_status_clear = iclr_r;
    // Read strobes reach the status registers in the read cycle itself,
    // so the returned word is the value before the clear.
    cfg.isr1_rd = host_rd_in && host_addr_in == `TTRC_ISR1_ADDR;
    cfg.isr2_rd = host_rd_in && host_addr_in == `TTRC_ISR2_ADDR;
  end

  // Host write decode and the configuration register.
  always_comb
  begin
    wr_cfg2 = host_wr_in && host_addr_in == `TTRC_CFG2_ADDR;
    wr_strt = host_wr_in && host_addr_in == `TTRC_STRT_ADDR;
    cfg2_nxt = wr_cfg2 ? host_wdata_in : cfg2_r;
    inc_nxt = wr_strt && host_wdata_in[`TTRC_INC_BIT]; // [R16]
    trst_nxt = wr_strt && host_wdata_in[`TTRC_TRST_BIT];
    iclr_nxt = wr_strt && host_wdata_in[`TTRC_ICLR_BIT]; // [R8]
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cfg2_r <= `TTRC_CFG2_RST;
      inc_r <= 1'b0;
      trst_r <= 1'b0;
      iclr_r <= 1'b0;
    end
    else
    begin
      cfg2_r <= cfg2_nxt;
      inc_r <= inc_nxt;
      trst_r <= trst_nxt;
      iclr_r <= iclr_nxt;
    end
  end

  // Host read path. The start/reset address is write only here; the stack
  // pointer that shares it lives outside this block and reads as zero.
  always_comb
  begin
    rdata_nxt = host_rdata_out;
    if (host_rd_in)
    begin
      unique case (host_addr_in)
        `TTRC_CFG2_ADDR: rdata_nxt = cfg2_r;
        `TTRC_ISR1_ADDR: rdata_nxt = isr1;
        `TTRC_ISR2_ADDR: rdata_nxt = isr2;
        `TTRC_TAG_ADDR: rdata_nxt = tag_value_out;
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      host_rdata_out <= '0;
    else
      host_rdata_out <= rdata_nxt;
  end

  // Terminal side decisions driven from the configuration fields.
  always_comb
  begin
    // A host write in the same cycle as the auto clear wins, so a
    // fresh request from software is never dropped.
    if (svc_req_wr_in)
      svc_nxt = svc_req_val_in;
    else if (cfg2_r[`TTRC_SRAC_BIT] && vector_answered_in)
      svc_nxt = 1'b0; // [R11]
    else
      svc_nxt = svc_req_out;
    if (cfg2_r[`TTRC_ENH_BIT])
      dbl_nxt = rx_sa_ctrl_double_in; // [R13]
    else
      dbl_nxt = cfg2_r[`TTRC_DBUF_BIT]; // [R12]
    // Shared storage simply means the broadcast buffer is never chosen.
    bcst_nxt = cfg2_r[`TTRC_BSEP_BIT] && rx_bcst_cmd_in; // [R14] [R15]
    if (bc_mode && cfg2_r[`TTRC_SYNC_DATA_TO_TAG_BIT])
      bc_word_nxt = tag_value_out; // [R6]
    else
      bc_word_nxt = bc_msg_word_in;
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      svc_req_out <= 1'b0;
      rx_double_buf_out <= 1'b0;
      rx_bcst_buf_out <= 1'b0;
      bc_sync_word_out <= '0;
    end
    else
    begin
      svc_req_out <= svc_nxt;
      rx_double_buf_out <= dbl_nxt;
      rx_bcst_buf_out <= bcst_nxt;
      bc_sync_word_out <= bc_word_nxt;
    end
  end

  ttrc_time_tag #(
    .TAG_BASE_CYC(TAG_BASE_CYC),
    .PW(16)
  ) u_tag (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .cfg(cfg.tag),
    .rt_mode_in(rt_mode), // [R4] [R5]
    .tag_clk_in(tag_clk_in),
    .sync_nodata_in(sync_nodata_rx_in),
    .sync_data_in(sync_data_rx_in),
    .sync_word_in(sync_word_in),
    .tag_out(tag_value_out)
  );

  ttrc_irq #(
    .PULSE_CYC(PULSE_CYC)
  ) u_irq (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .cfg(cfg.irq),
    .ev1_in(irq_events1_in),
    .ev2_in(irq_events2_in),
    .isr1_out(isr1),
    .isr2_out(isr2),
    .int_n_out(int_n_out)
  );

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  property p_bc_sync;
    bc_mode && cfg2_r[`TTRC_SYNC_DATA_TO_TAG_BIT]
      |=> bc_sync_word_out == $past(tag_value_out);
  endproperty
  a_bc_sync: assert property (p_bc_sync) // [R6]
    else $error("BC sync word is not the tag value");
  property p_svc_host_only;
    !cfg2_r[`TTRC_SRAC_BIT] && !svc_req_wr_in |=> $stable(svc_req_out);
  endproperty
  a_svc_host_only: assert property (p_svc_host_only) // [R11]
    else $error("service request moved without a host write");
  property p_svc_auto;
    cfg2_r[`TTRC_SRAC_BIT] && vector_answered_in && !svc_req_wr_in
      |=> !svc_req_out;
  endproperty
  a_svc_auto: assert property (p_svc_auto) // [R11]
    else $error("service request not cleared after vector answer");
  property p_global_buf;
    !cfg2_r[`TTRC_ENH_BIT]
      |=> rx_double_buf_out == $past(cfg2_r[`TTRC_DBUF_BIT]);
  endproperty
  a_global_buf: assert property (p_global_buf) // [R12]
    else $error("global receive buffering mode wrong");
  property p_sa_buf;
    cfg2_r[`TTRC_ENH_BIT] |=> rx_double_buf_out == $past(rx_sa_ctrl_double_in);
  endproperty
  a_sa_buf: assert property (p_sa_buf) // [R13]
    else $error("subaddress buffering mode not followed");
  property p_bcst;
    rx_bcst_cmd_in |=> rx_bcst_buf_out == $past(cfg2_r[`TTRC_BSEP_BIT]);
  endproperty
  a_bcst: assert property (p_bcst) // [R14] [R15]
    else $error("broadcast buffer choice wrong");
  property p_iclr;
    wr_strt && host_wdata_in[`TTRC_ICLR_BIT] && irq_events1_in == '0 &&
      irq_events2_in == '0 ##1 irq_events1_in == '0 && irq_events2_in == '0
      |=> isr1 == '0 && isr2 == '0;
  endproperty
  a_iclr: assert property (p_iclr) // [R8]
    else $error("clear bit did not clear both status registers");
  c_bc_sync: cover property (bc_mode && cfg2_r[`TTRC_SYNC_DATA_TO_TAG_BIT]);
  c_svc_auto: cover property (cfg2_r[`TTRC_SRAC_BIT] && vector_answered_in);
endmodule : ttrc_top

// ### bench/ttrc_host_model.sv
// Host processor model that drives the parallel register bus.
`timescale 1ns/1ns
`include "ttrc_regs.svh"
module ttrc_host_model (
  input wire logic clk_in,
  input wire logic [15:0] rdata_in,
  output logic [`TTRC_ADDR_W-1:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [15:0] wdata_out
);
  initial
  begin
    addr_out = 11'h000;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 16'h0000;
  end

  // Idle lines carry the inverse of the last value, so no stale match.
  task automatic wr(input logic [10:0] a, input logic [15:0] d);
    @(posedge clk_in);
    #1;
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(posedge clk_in);
    #1;
    wr_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask : wr

  task automatic rd(input logic [10:0] a, output logic [15:0] d);
    @(posedge clk_in);
    #1;
    addr_out = a;
    rd_out = 1'b1;
    @(posedge clk_in);
    #1;
    rd_out = 1'b0;
    addr_out = ~a;
    d = rdata_in;
  endtask : rd

  task automatic strt(input logic [15:0] bits);
    wr(`TTRC_STRT_ADDR, bits);
  endtask : strt

  task automatic irq_clear();
    strt(16'h0001 << `TTRC_ICLR_BIT);
  endtask : irq_clear
endmodule : ttrc_host_model

// ### bench/tb.sv
// Self-checking testbench for the time tag and terminal config block.
`timescale 1ns/1ns
`include "ttrc_regs.svh"
module tb;
  localparam int BASE = 4;
  localparam int PW = 4;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [`TTRC_ADDR_W-1:0] h_addr;
  logic h_wr;
  logic h_rd;
  logic [15:0] h_wdata;
  logic [15:0] h_rdata;
  logic [1:0] mode = 2'h0;
  logic tag_clk = 1'b0;
  logic s_nd = 1'b0;
  logic s_dd = 1'b0;
  logic [15:0] s_word = 16'h0000;
  logic [15:0] bc_msg = 16'h0000;
  logic [15:0] bc_sync;
  logic [15:0] tag;
  logic [15:0] ev1 = 16'h0000;
  logic [15:0] ev2 = 16'h0000;
  logic int_n;
  logic sv_wr = 1'b0;
  logic sv_val = 1'b0;
  logic vec = 1'b0;
  logic svc;
  logic sa_dbl = 1'b0;
  logic dbl;
  logic bcst = 1'b0;
  logic bbuf;
  int n_fail = 0;
  int compares = 0;

  always #4 core_clk_in = ~core_clk_in;

  ttrc_host_model u_host (.clk_in(core_clk_in), .rdata_in(h_rdata),
    .addr_out(h_addr), .wr_out(h_wr), .rd_out(h_rd), .wdata_out(h_wdata));

  ttrc_top #(.TAG_BASE_CYC(BASE), .PULSE_CYC(PW)) u_dut (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .host_addr_in(h_addr),
    .host_wr_in(h_wr), .host_rd_in(h_rd), .host_wdata_in(h_wdata),
    .host_rdata_out(h_rdata), .mode_in(mode), .tag_clk_in(tag_clk),
    .sync_nodata_rx_in(s_nd), .sync_data_rx_in(s_dd),
    .sync_word_in(s_word), .bc_msg_word_in(bc_msg),
    .bc_sync_word_out(bc_sync), .tag_value_out(tag),
    .irq_events1_in(ev1), .irq_events2_in(ev2), .int_n_out(int_n),
    .svc_req_wr_in(sv_wr), .svc_req_val_in(sv_val),
    .vector_answered_in(vec), .svc_req_out(svc),
    .rx_sa_ctrl_double_in(sa_dbl), .rx_double_buf_out(dbl),
    .rx_bcst_cmd_in(bcst), .rx_bcst_buf_out(bbuf));

  task automatic test_done();
    if (n_fail == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk_in);
    #1;
  endtask : cyc

  task automatic chk(input logic [15:0] got, exp, input string msg);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [10:0] a, input logic [15:0] exp);
    logic [15:0] d;
    u_host.rd(a, d);
    chk(d, exp, "read");
  endtask : rdchk

  task automatic cfg(input logic [15:0] v);
    u_host.wr(`TTRC_CFG2_ADDR, v);
  endtask : cfg

  // Counts cycles until the tag moves; a hang ends the run.
  task automatic tag_wait(output int k);
    logic [15:0] t0;
    t0 = tag;
    k = 0;
    while (tag === t0)
    begin
      cyc(1);
      k++;
      if (k > 600)
      begin
        chk(tag, ~t0, "tag stuck");
        test_done();
      end
    end
  endtask : tag_wait

  task automatic sync(input logic nd, dd, input logic [15:0] w);
    s_nd = nd;
    s_dd = dd;
    s_word = w;
    cyc(1);
    s_nd = 1'b0;
    s_dd = 1'b0;
    s_word = ~w;
    cyc(1);
  endtask : sync

  task automatic tclk(input int k);
    repeat (k)
    begin
      tag_clk = 1'b1;
      cyc(2);
      tag_clk = 1'b0;
      cyc(2);
    end
  endtask : tclk

  task automatic pulse_vec();
    vec = 1'b1;
    cyc(1);
    vec = 1'b0;
    cyc(1);
  endtask : pulse_vec

  initial
  begin
    int n;
    repeat (4) @(posedge core_clk_in);
    #1;
    rst_in = 1'b0;
    chk(int_n, 16'h0001, "int idle");
    chk(tag, 16'h0000, "tag reset");
    rdchk(`TTRC_CFG2_ADDR, 16'h0000);
    cfg(16'hC35A);
    u_host.wr(11'h7FF, 16'h1234);
    rdchk(`TTRC_CFG2_ADDR, 16'hC35A);
    rdchk(11'h7FF, 16'h0000);
    rdchk(`TTRC_STRT_ADDR, 16'h0000);
    for (int c = 0; c < 6; c++)
    begin
      cfg(16'(c) << 7);
      tag_wait(n);
      tag_wait(n);
      chk(16'(n), 16'(BASE << (5 - c)), "period");
    end
    mode = ttrc_pkg::TTRC_RT;
    cfg(16'h0020);
    tag_wait(n);
    sync(1'b0, 1'b1, 16'hFFFF);
    chk(tag, 16'hFFFF, "sync load");
    tag_wait(n);
    chk(tag, 16'h0000, "wrap");
    cfg(16'h0360);
    u_host.strt(16'h0008);
    repeat (3) u_host.strt(16'h0010);
    cyc(2);
    chk(tag, 16'h0003, "soft inc");
    cyc(40);
    tclk(2);
    chk(tag, 16'h0003, "soft hold");
    sync(1'b1, 1'b0, 16'h0000);
    chk(tag, 16'h0000, "sync clear");
    sync(1'b0, 1'b1, 16'h1234);
    chk(tag, 16'h1234, "sync data");
    cfg(16'h0300);
    sync(1'b1, 1'b0, 16'h0000);
    sync(1'b0, 1'b1, 16'h5555);
    chk(tag, 16'h1234, "sync off");
    mode = ttrc_pkg::TTRC_BC;
    bc_msg = 16'hA5A5;
    cfg(16'h0360);
    sync(1'b1, 1'b0, 16'h0000);
    chk(tag, 16'h1234, "bc sync clr");
    chk(bc_sync, 16'h1234, "bc tag word");
    cfg(16'h0300);
    cyc(2);
    chk(bc_sync, 16'hA5A5, "bc msg word");
    cfg(16'h0380);
    u_host.strt(16'h0010);
    cyc(2);
    chk(tag, 16'h1234, "inc ignored");
    tclk(3);
    cyc(2);
    chk(tag, 16'h1237, "ext clock");
    rdchk(`TTRC_TAG_ADDR, 16'h1237);
    cfg(16'h0018);
    ev1 = 16'h0005;
    ev2 = 16'h8001;
    cyc(1);
    ev1 = 16'h0000;
    ev2 = 16'h0000;
    cyc(1);
    rdchk(`TTRC_ISR1_ADDR, 16'h0005);
    chk(int_n, 16'h0000, "level");
    rdchk(`TTRC_ISR1_ADDR, 16'h0000);
    rdchk(`TTRC_ISR2_ADDR, 16'h8001);
    cyc(1);
    chk(int_n, 16'h0001, "level off");
    rdchk(`TTRC_ISR2_ADDR, 16'h0000);
    cfg(16'h0008);
    ev1 = 16'h0003;
    ev2 = 16'h0004;
    cyc(1);
    ev1 = 16'h0000;
    ev2 = 16'h0000;
    rdchk(`TTRC_ISR1_ADDR, 16'h0003);
    rdchk(`TTRC_ISR1_ADDR, 16'h0003);
    rdchk(`TTRC_ISR2_ADDR, 16'h0004);
    cyc(20);
    chk(int_n, 16'h0000, "level hold");
    u_host.irq_clear();
    cyc(2);
    chk(int_n, 16'h0001, "cleared");
    rdchk(`TTRC_ISR1_ADDR, 16'h0000);
    rdchk(`TTRC_ISR2_ADDR, 16'h0000);
    cfg(16'h0000);
    ev1 = 16'h0001;
    cyc(1);
    ev1 = 16'h0000;
    n = 0;
    while (int_n === 1'b0 && n < 100)
    begin
      n++;
      cyc(1);
    end
    chk(16'(n), 16'(PW), "pulse width");
    chk(int_n, 16'h0001, "pulse end");
    sv_wr = 1'b1;
    sv_val = 1'b1;
    cyc(1);
    sv_wr = 1'b0;
    cyc(1);
    pulse_vec();
    chk(svc, 16'h0001, "svc host only");
    cfg(16'h0004);
    pulse_vec();
    chk(svc, 16'h0000, "svc autoclear");
    for (int i = 0; i < 16; i++)
    begin
      sa_dbl = i[2];
      bcst = ~i[2];
      cfg({3'h0, i[1], 10'h000, i[0], i[3]});
      cyc(2);
      chk(dbl, i[0] ? i[2] : i[1], "buffering");
      chk(bbuf, i[3] & ~i[2], "bcst store");
    end
    test_done();
  end
endmodule : tb
